// ### vds_map.svh
// Purpose: Constants for the voltage select slew control block.
// Assumes: 125 MHz system clock.
// Notes:   Times are kept in picoseconds; cycle counts are derived from them.
`ifndef VDS_MAP_SVH
`define VDS_MAP_SVH
`define VDS_CLK_PERIOD_PS   8000
`define VDS_SAMPLE_PERIOD_PS 180180
`define VDS_STEP_PERIOD_PS  540000
`define VDS_SAMPLE_CYCLES   (`VDS_SAMPLE_PERIOD_PS / `VDS_CLK_PERIOD_PS)
`define VDS_STEP_SAMPLES    3
`define VDS_CODE_STABLE     3
`define VDS_OFF_STABLE      4
`define VDS_OFF_MASK        8'hFE
`define VDS_CODE_RESET      8'hFF
`define VDS_STEP_MV_X100    625
`endif

// ### vds_pkg.sv
// Purpose: Types for the voltage select slew control block.
// Assumes: Nothing beyond the constants header.
// Notes:   Status bundle travels as one packed struct.
`default_nettype none
package vds_pkg;
  typedef logic [7:0] vds_code_type;
  typedef struct packed {
    logic       regulating;
    logic       latched_off;
    logic       slewing;
  } vds_status_type;
endpackage
`default_nettype wire

// ### vds_slew_step.sv
// Purpose: Moves the reference code one count per step toward a target.
// Assumes: step_en_i is a one-cycle pulse at the stepping rate.
// Notes:   Higher code means lower voltage; only the code is stepped here.
`timescale 1ns/1ps
`default_nettype none
`include "vds_map.svh"
module vds_slew_step
  import vds_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         step_en_i,
  input  wire logic         hold_i,
  input  wire vds_code_type target_i,
  output var  vds_code_type dac_code_o
);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dac_code_o <= `VDS_CODE_RESET;
    end else if (step_en_i && !hold_i) begin
      // One count per step, either direction, from the present code.
      if (dac_code_o < target_i) begin
        dac_code_o <= dac_code_o + 8'h01;
      end else if (dac_code_o > target_i) begin
        dac_code_o <= dac_code_o - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### vds_ctrl.sv
// Purpose: Samples, debounces and slews the voltage select code; latches off codes.
// Assumes: voltage_select_code_i and enable_i are synchronous to clk_i.
// Notes:   Sampling rate is the system clock divided by 22, about 5.68 MHz.
// Summary of operation
// - Sample select inputs each sampling edge and compare with the previous sample.
// - Accept an ordinary code after three identical successive samples.
// - Step the DAC code one count toward target at the stepping rate.
// - Keep stepping every step period until DAC code equals target.
// - A recognized off code stops regulation instead of stepping.
// - Recognize an off code after four identical successive samples.
// - Off state is latched; cleared only by enable low then high.
// - Codes with upper seven bits all ones are off codes.
`timescale 1ns/1ps
`default_nettype none
`include "vds_map.svh"
module vds_ctrl
  import vds_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           enable_i,
  input  wire vds_code_type   voltage_select_code_i,
  output var  vds_code_type   dac_code_o,
  output var  vds_code_type   target_o,
  output var  vds_status_type status_o
);
  localparam int SAMPLE_CYCLES = `VDS_SAMPLE_CYCLES;

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  logic [4:0] div_cnt;
  logic       sample_en;
  logic [1:0] step_div;
  logic       step_en;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt   <= 5'h00;
      sample_en <= 1'b0;
    end else if (div_cnt == 5'(SAMPLE_CYCLES - 1)) begin
      div_cnt   <= 5'h00;
      sample_en <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 5'h01;
      sample_en <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      step_div <= 2'h0;
      step_en  <= 1'b0;
    end else if (sample_en) begin
      step_en  <= (step_div == 2'(`VDS_STEP_SAMPLES - 1));
      step_div <= (step_div == 2'(`VDS_STEP_SAMPLES - 1)) ? 2'h0 : step_div + 2'h1;
    end else begin
      step_en  <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sampling and stability count
  // ----------------------------------------
  vds_code_type last_sample;
  logic [2:0]   stable_cnt;
  logic         sample_is_off;
  vds_code_type dac_code;

  assign sample_is_off = ((voltage_select_code_i & `VDS_OFF_MASK) == `VDS_OFF_MASK);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      last_sample <= `VDS_CODE_RESET;
      stable_cnt  <= 3'h0;
    end else if (sample_en) begin
      last_sample <= voltage_select_code_i;
      if (voltage_select_code_i != last_sample) begin
        stable_cnt <= 3'h1;
      end else if (stable_cnt != 3'h7) begin
        stable_cnt <= stable_cnt + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Target acceptance and off latch
  // ----------------------------------------
  logic enable_q;
  logic rearm;
  logic off_seen;
  logic code_seen;
  logic rearm_edge;

  // A code is judged on the sample that completes its run of identical readings.
  assign off_seen   = sample_en && sample_is_off && voltage_select_code_i == last_sample &&
                      stable_cnt == 3'(`VDS_OFF_STABLE - 1);
  assign code_seen  = sample_en && !sample_is_off && voltage_select_code_i == last_sample &&
                      stable_cnt == 3'(`VDS_CODE_STABLE - 1);
  assign rearm_edge = enable_i && !enable_q && rearm;

  // Comparing with the target as well as the DAC code lets a code that the
  // DAC is only passing through still become the new end point.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      target_o <= `VDS_CODE_RESET;
    end else if (code_seen && (voltage_select_code_i != dac_code ||
                               voltage_select_code_i != target_o)) begin
      target_o <= voltage_select_code_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable_q <= 1'b0;
      rearm    <= 1'b0;
    end else begin
      enable_q <= enable_i;
      if (!enable_i) begin
        rearm <= 1'b1;
      end else if (rearm_edge) begin
        rearm <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Reference stepping and status
  // ----------------------------------------
  vds_slew_step u_step (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .step_en_i  (step_en),
    .hold_i     (status_o.latched_off),
    .target_i   (target_o),
    .dac_code_o (dac_code)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dac_code_o <= `VDS_CODE_RESET;
    end else begin
      dac_code_o <= dac_code;
    end
  end

  // The set wins over a clear in the same cycle, so an off code is never lost.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_o.regulating  <= 1'b0;
      status_o.latched_off <= 1'b0;
      status_o.slewing     <= 1'b0;
    end else begin
      status_o.regulating <= enable_i && !status_o.latched_off;
      status_o.slewing    <= (dac_code != target_o) && !status_o.latched_off;
      if (off_seen) begin
        status_o.latched_off <= 1'b1;
      end else if (rearm_edge) begin
        status_o.latched_off <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_same_sample;
    sample_en && voltage_select_code_i == last_sample;
  endsequence

  sequence s_code_run;
    s_same_sample ##0 stable_cnt == 3'(`VDS_CODE_STABLE - 1);
  endsequence

  sequence s_off_run;
    s_same_sample ##0 stable_cnt == 3'(`VDS_OFF_STABLE - 1);
  endsequence

  a_step_one_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> (dac_code == $past(dac_code) || dac_code == $past(dac_code) + 8'h01 ||
              dac_code == $past(dac_code) - 8'h01))
    else $error("DAC code moved by more than one count");
  a_step_only_on_en: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !step_en |=> dac_code == $past(dac_code))
    else $error("DAC code moved without a step pulse");
  a_step_toward: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step_en && !status_o.latched_off && dac_code < target_o) |=>
      dac_code == $past(dac_code) + 8'h01)
    else $error("DAC code failed to step toward target");
  a_off_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_o.latched_off |=> dac_code == $past(dac_code))
    else $error("DAC code stepped while latched off");
  a_off_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (status_o.latched_off && !(enable_i && !enable_q)) |=> status_o.latched_off)
    else $error("Off latch cleared without enable toggle");
  a_target_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(target_o) |-> $past(stable_cnt) == 3'(`VDS_CODE_STABLE - 1))
    else $error("Target taken before three stable samples");
  a_off_four: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(status_o.latched_off) |-> $past(stable_cnt) == 3'(`VDS_OFF_STABLE - 1))
    else $error("Off code latched before four stable samples");
  a_restart_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sample_en && voltage_select_code_i != last_sample) |=> stable_cnt == 3'h1)
    else $error("Stability count not restarted on change");
  a_off_not_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_same_sample ##0 sample_is_off |=> target_o == $past(target_o))
    else $error("Off code taken as a target");
  a_sample_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sample_en |=> !sample_en [*8])
    else $error("Sampling pulses too close together");
  a_accept_third: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_code_run ##0 (!sample_is_off && voltage_select_code_i != target_o) |=>
      target_o == $past(voltage_select_code_i))
    else $error("Stable code not taken as target");
  a_off_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_off_run ##0 sample_is_off |=> status_o.latched_off)
    else $error("Stable off code not latched");
  a_latch_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rearm_edge && !off_seen) |=> !status_o.latched_off)
    else $error("Off latch kept after enable toggle");
  a_off_no_reg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_o.latched_off |=> !status_o.regulating)
    else $error("Regulating while latched off");
  a_step_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step_en && !status_o.latched_off && dac_code > target_o) |=>
      dac_code == $past(dac_code) - 8'h01)
    else $error("DAC code failed to step down toward target");
endmodule
`default_nettype wire

// ### vds_cpu_model.sv
// Purpose: Processor model that drives the voltage select code.
// Assumes: A request on next_code_i shows on code_o one clock later.
// Notes:   The code is a plain level with no strobe beside it.
`timescale 1ns/1ps
`default_nettype none
module vds_cpu_model
  import vds_pkg::*;
(
  input  wire logic         clk_i,
  input  wire vds_code_type next_code_i,
  output var  vds_code_type code_o
);
  always @(posedge clk_i) begin
    code_o <= next_code_i;
  end
endmodule
`default_nettype wire

// ### tb_voltage_code_dac_slew_control.sv
// Purpose: Self-checking bench for the voltage select slew control.
// Assumes: Sampling every 22 clocks and a step every 66 clocks.
// Notes:   Outputs are read 1 ns after the edge so that they have settled.
`timescale 1ns/1ps
`default_nettype none
module tb_voltage_code_dac_slew_control;
  import vds_pkg::*;
  logic           clk_i;
  logic           rst_n_i;
  logic           enable_i;
  vds_code_type   next_code;
  vds_code_type   code;
  vds_code_type   dac_code;
  vds_code_type   target;
  vds_status_type status;
  int             num_errors = 0;
  int             n_compared = 0;
  int             n;
  vds_cpu_model u_cpu (.clk_i(clk_i), .next_code_i(next_code), .code_o(code));
  vds_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
    .voltage_select_code_i(code), .dac_code_o(dac_code), .target_o(target),
    .status_o(status));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Waits up to lim clocks for target (0), DAC code (1) or status (2) to show v.
  task automatic wait_for(input int sel, input logic [7:0] v, input int lim);
    n = 0;
    while (((sel == 0) ? target : (sel == 1) ? dac_code : 8'(status)) !== v && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask
  task automatic drive(input vds_code_type v, input int cycles);
    @(posedge clk_i);
    next_code <= v;
    repeat (cycles) @(posedge clk_i);
    #1;
  endtask
  task automatic t_accept();
    drive(8'h80, 0);
    wait_for(0, 8'h80, 120);
    check("accept delay", 8'h01, 8'(n >= 44));
    check("target", 8'h80, target);
    wait_for(1, 8'h80, 9000);
    check("dac", 8'h80, dac_code);
    drive(8'h82, 0);
    wait_for(1, 8'h81, 200);
    wait_for(1, 8'h82, 200);
    check("step gap", 8'h42, 8'(n));
  endtask
  task automatic t_toggle();
    repeat (20) begin
      drive(8'h90, 6);
      drive(8'h91, 6);
    end
    check("target", 8'h82, target);
  endtask
  task automatic t_off();
    drive(8'hFE, 60);
    drive(8'h82, 100);
    check("short off", 8'h00, 8'(status.latched_off));
    drive(8'hFF, 0);
    wait_for(2, 8'h02, 120);
    check("off delay", 8'h01, 8'(n >= 66));
    check("off status", 8'h02, 8'(status));
    drive(8'h60, 300);
    check("latched", 8'h02, 8'(status));
    check("dac frozen", 8'h82, dac_code);
    @(posedge clk_i);
    enable_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    enable_i <= 1'b1;
    #1;
    check("held low", 8'h02, 8'(status));
    wait_for(2, 8'h05, 20);
    check("unlatched", 8'h00, 8'(status.latched_off));
    check("target", 8'h60, target);
  endtask
  task automatic t_turn();
    wait_for(1, 8'h80, 300);
    drive(8'h84, 0);
    wait_for(1, 8'h84, 500);
    check("reversed", 8'h84, dac_code);
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("reset dac", 8'hFF, dac_code);
    check("reset target", 8'hFF, target);
    check("reset status", 8'h00, 8'(status));
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    wait_for(0, 8'h84, 120);
    check("target again", 8'h84, target);
  endtask
  initial begin
    rst_n_i = 1'b0;
    enable_i = 1'b1;
    next_code = 8'h80;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_accept();
    t_toggle();
    t_off();
    t_turn();
    t_reset();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
